// ==== rtl/nvw_consts.svh ====
// Offsets, field positions, key values and timing figures of the nonvolatile write controller
`ifndef NVW_CONSTS_SVH
`define NVW_CONSTS_SVH

// ==========================================================
// Register byte offsets on APB
`define NVW_OFF_CTRL 12'h000
`define NVW_OFF_KEY 12'h004
`define NVW_OFF_DATA 12'h008
`define NVW_OFF_ADDR 12'h00c
`define NVW_OFF_IRQ_STAT 12'h010
`define NVW_OFF_IRQ_MASK 12'h014

// ==========================================================
// Control register fields
`define NVW_CTRL_MEM_SEL 7
`define NVW_CTRL_CFG_SEL 6
`define NVW_CTRL_ROW_ERASE 4
`define NVW_CTRL_WR_ERR 3
`define NVW_CTRL_WRITE_ENABLE_BIT 2
`define NVW_CTRL_START 1
`define NVW_CTRL_READ 0
`define NVW_CTRL_RESET 8'h00

// ==========================================================
// Interrupt status and mask fields
`define NVW_IRQ_DONE 0
`define NVW_IRQ_ERR 1
`define NVW_IRQ_RESET 2'h0

// ==========================================================
// Unlock keys
`define NVW_KEY_FIRST 8'h55
`define NVW_KEY_SECOND 8'haa

// ==========================================================
// Timing
`define NVW_CLK_MHZ 40
`define NVW_PWRT_US 1000
`define NVW_WRITE_US 4000
`define NVW_PWRT_CYCLES (`NVW_PWRT_US * `NVW_CLK_MHZ)
`define NVW_WRITE_CYCLES (`NVW_WRITE_US * `NVW_CLK_MHZ)

`endif

// ==== rtl/nvw_pkg.sv ====
// Types shared by the nonvolatile write controller
package nvw_pkg;

	typedef logic [7:0] nvw_byte_t;

	typedef enum logic [1:0] {
		NVW_UNLOCK_IDLE,
		NVW_UNLOCK_KEY1,
		NVW_UNLOCK_ARMED
	} nvw_unlock_e;

	typedef struct packed {
		logic mem_sel;
		logic cfg_sel;
		logic unused;
		logic row_erase;
		logic wr_err;
		logic write_enable_bit;
		logic start;
		logic read;
	} nvw_ctrl_s;

endpackage

// ==== rtl/nvw_tmr_if.sv ====
// Handshake between the controller and its self-timed write engine
interface nvw_tmr_if;
	logic start;
	logic busy;
	logic done;

	modport ctrl (output start, input busy, input done);
	modport tmr (input start, output busy, output done);
endinterface

// ==== rtl/nvw_write_timer.sv ====
// Self-timed write cycle counter
module nvw_write_timer #(
	parameter int unsigned CYCLES = 160000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	nvw_tmr_if.tmr t
);
	import nvw_pkg::*;

	logic [31:0] cnt;

	// ==========================================================
	// Count down one write period, then a one-cycle done
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h0;
			t.busy <= 1'b0;
			t.done <= 1'b0;
		end else begin
			t.done <= 1'b0;
			if (t.start && !t.busy) begin
				cnt <= 32'(CYCLES - 1);
				t.busy <= 1'b1;
			end else if (t.busy) begin
				if (cnt == 32'h0) begin
					t.busy <= 1'b0;
					t.done <= 1'b1;
				end else begin
					cnt <= cnt - 32'h1;
				end
			end
		end
	end
endmodule

// ==== rtl/nvw_ctrl.sv ====
// Nonvolatile data array with keyed, self-timed byte writes behind APB
//
// Added by the designer: the APB register port and the address map.
`include "nvw_consts.svh"

module nvw_ctrl #(
	parameter int AW = 8,
	parameter int unsigned PWRT_CYCLES = `NVW_PWRT_CYCLES,
	parameter int unsigned WRITE_CYCLES = `NVW_WRITE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic code_protect,
	input wire logic ext_req,
	input wire logic ext_we,
	input wire logic [AW-1:0] ext_addr,
	input wire nvw_pkg::nvw_byte_t ext_wdata,
	output nvw_pkg::nvw_byte_t ext_rdata,
	output logic ext_ack,
	output logic ext_denied,
	output logic pwrt_running,
	output logic irq
);
	import nvw_pkg::*;

	// ==========================================================
	// State
	nvw_byte_t mem [0:(1<<AW)-1];
	nvw_ctrl_s ctrl;
	nvw_byte_t data_reg;
	logic [AW-1:0] addr_reg;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	nvw_unlock_e unlock;
	logic [31:0] pwrt_cnt;
	logic pwrt_done;

	nvw_tmr_if tmr ();

	// ==========================================================
	// Bus decode
	logic acc;
	logic wr_acc;
	logic setup;
	logic hit;
	logic ctrl_wr;
	logic key_wr;
	logic data_wr;
	logic addr_wr;
	logic stat_wr;
	logic mask_wr;
	logic busy;
	logic start_req;
	logic start_ok;
	logic start_bad;
	logic ext_ok;
	logic [1:0] irq_evt;
	logic launch;

	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign setup = psel && !penable;
	assign hit = (paddr == `NVW_OFF_CTRL) || (paddr == `NVW_OFF_KEY) ||
		(paddr == `NVW_OFF_DATA) || (paddr == `NVW_OFF_ADDR) ||
		(paddr == `NVW_OFF_IRQ_STAT) || (paddr == `NVW_OFF_IRQ_MASK);
	assign ctrl_wr = wr_acc && (paddr == `NVW_OFF_CTRL);
	assign key_wr = wr_acc && (paddr == `NVW_OFF_KEY);
	assign data_wr = wr_acc && (paddr == `NVW_OFF_DATA);
	assign addr_wr = wr_acc && (paddr == `NVW_OFF_ADDR);
	assign stat_wr = wr_acc && (paddr == `NVW_OFF_IRQ_STAT);
	assign mask_wr = wr_acc && (paddr == `NVW_OFF_IRQ_MASK);

	// Zero wait states; unmapped offsets answer with an error
	assign pready = 1'b1;
	assign pslverr = acc && !hit;

	// The start bit itself is the busy lock
	assign busy = ctrl.start;

	// ==========================================================
	// Start qualification
	// Old write enable is checked, so one write setting both never starts
	assign start_req = ctrl_wr && pwdata[`NVW_CTRL_START] && !busy;
	assign start_ok = start_req && (unlock == NVW_UNLOCK_ARMED) &&
		ctrl.write_enable_bit &&
		pwrt_done &&
		!ctrl.mem_sel && !ctrl.cfg_sel;
	assign start_bad = start_req && !start_ok;

	// ==========================================================
	// Unlock tracker
	// A read counts as an access too, so a stray poll disarms the sequence
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unlock <= NVW_UNLOCK_IDLE;
		end else if (acc) begin
			case (unlock)
				NVW_UNLOCK_IDLE: begin
					if (key_wr && pwdata[7:0] == `NVW_KEY_FIRST) begin
						unlock <= NVW_UNLOCK_KEY1;
					end
				end
				NVW_UNLOCK_KEY1: begin
					if (key_wr && pwdata[7:0] == `NVW_KEY_SECOND) begin
						unlock <= NVW_UNLOCK_ARMED;
					end else begin
						unlock <= NVW_UNLOCK_IDLE;
					end
				end
				NVW_UNLOCK_ARMED: begin
					unlock <= NVW_UNLOCK_IDLE;
				end
				default: begin
					unlock <= NVW_UNLOCK_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Power-up timer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwrt_cnt <= 32'h0;
			pwrt_done <= 1'b0;
		end else if (!pwrt_done) begin
			if (pwrt_cnt == 32'(PWRT_CYCLES - 1)) begin
				pwrt_done <= 1'b1;
			end else begin
				pwrt_cnt <= pwrt_cnt + 32'h1;
			end
		end
	end

	assign pwrt_running = !pwrt_done;

	// ==========================================================
	// Control register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `NVW_CTRL_RESET;
		end else begin
			if (ctrl.read) begin
				ctrl.read <= 1'b0;
			end
			if (tmr.done) begin
				ctrl.start <= 1'b0;
			end
			if (ctrl_wr && !busy) begin
				ctrl.mem_sel <= pwdata[`NVW_CTRL_MEM_SEL];
				ctrl.cfg_sel <= pwdata[`NVW_CTRL_CFG_SEL];
				ctrl.row_erase <= pwdata[`NVW_CTRL_ROW_ERASE];
				ctrl.write_enable_bit <= pwdata[`NVW_CTRL_WRITE_ENABLE_BIT];
				ctrl.wr_err <= pwdata[`NVW_CTRL_WR_ERR] || start_bad;
				if (start_ok) begin
					ctrl.start <= 1'b1;
				end
				if (pwdata[`NVW_CTRL_READ] && !ctrl.mem_sel && !ctrl.cfg_sel) begin
					ctrl.read <= 1'b1;
				end
			end
		end
	end

	// One-cycle launch: a level would restart the timer as it ends
	// And a second completion would then set the flag again
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			launch <= 1'b0;
		end else begin
			launch <= start_ok;
		end
	end

	assign tmr.start = launch;

	nvw_write_timer #(
		.CYCLES(WRITE_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.t(tmr)
	);

	// ==========================================================
	// Address and data registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= '0;
		end else if (addr_wr && !busy) begin
			addr_reg <= pwdata[AW-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= 8'h00;
		end else if (ctrl.read) begin
			data_reg <= mem[addr_reg];
		end else if (data_wr && !busy) begin
			data_reg <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Array and external port
	// External access loses to a running write rather than corrupting it
	assign ext_ok = !code_protect && !busy && pwrt_done;

	always_ff @(posedge clk_sys) begin
		if (tmr.done) begin
			mem[addr_reg] <= data_reg;
		end else if (ext_req && ext_we && ext_ok) begin
			mem[ext_addr] <= ext_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_rdata <= 8'h00;
			ext_ack <= 1'b0;
			ext_denied <= 1'b0;
		end else begin
			ext_ack <= ext_req && ext_ok;
			ext_denied <= ext_req && !ext_ok;
			if (ext_req && !ext_we && ext_ok) begin
				ext_rdata <= mem[ext_addr];
			end
		end
	end

	// ==========================================================
	// Interrupts
	assign irq_evt[`NVW_IRQ_DONE] = tmr.done;
	assign irq_evt[`NVW_IRQ_ERR] = start_bad;

	// Set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= `NVW_IRQ_RESET;
		end else if (stat_wr) begin
			irq_stat <= (irq_stat & ~pwdata[1:0]) | irq_evt;
		end else begin
			irq_stat <= irq_stat | irq_evt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= `NVW_IRQ_RESET;
		end else if (mask_wr) begin
			irq_mask <= pwdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ==========================================================
	// Read data, captured in the setup phase
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0;
		end else if (setup && !pwrite) begin
			case (paddr)
				`NVW_OFF_CTRL: prdata <= {24'h0, ctrl.mem_sel, ctrl.cfg_sel, 1'b0, ctrl[4:0]};
				`NVW_OFF_KEY: prdata <= 32'h0;
				`NVW_OFF_DATA: prdata <= {24'h0, data_reg};
				`NVW_OFF_ADDR: prdata <= 32'(addr_reg);
				`NVW_OFF_IRQ_STAT: prdata <= {30'h0, irq_stat};
				`NVW_OFF_IRQ_MASK: prdata <= {30'h0, irq_mask};
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule

// ==== dv/nvw_ctrl_sva.sv ====
// Port checks for the nonvolatile write controller
`include "nvw_consts.svh"
module nvw_ctrl_sva #(
	parameter int unsigned PWRT_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic code_protect,
	input wire logic ext_req,
	input wire logic ext_ack,
	input wire logic ext_denied,
	input wire logic pwrt_running
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned since_rst;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Cycles since reset; saturates so it can never wrap back
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			since_rst <= 0;
		end else if (since_rst < PWRT_CYCLES + 8) begin
			since_rst <= since_rst + 1;
		end
	end
	sequence s_key_read;
		psel && !penable && !pwrite && paddr == `NVW_OFF_KEY;
	endsequence
	sequence s_ext_refused;
		ext_req && (code_protect || pwrt_running);
	endsequence
	// ==========================================================
	// Assertions
	a_key_reads_zero: assert property (s_key_read |=> prdata == 32'h0)
		else $error("key register read not zero");
	a_refused_ext: assert property (s_ext_refused |=> ext_denied && !ext_ack)
		else $error("blocked external access not refused");
	a_denied_cause: assert property (ext_denied |-> $past(ext_req))
		else $error("refusal without request");
	a_ack_cause: assert property (ext_ack |-> $past(ext_req) && !$past(code_protect) && !$past(pwrt_running))
		else $error("external access granted while blocked");
	a_pulse_excl: assert property (not (ext_ack && ext_denied))
		else $error("grant and refusal together");
	a_pwrt_holds: assert property (since_rst < PWRT_CYCLES |-> pwrt_running)
		else $error("power-up block ended early");
	a_pwrt_ends: assert property (since_rst > PWRT_CYCLES + 2 |-> !pwrt_running)
		else $error("power-up block never ended");
	a_pwrt_once: assert property (!pwrt_running |=> $stable(pwrt_running))
		else $error("power-up block came back");
endmodule

bind nvw_ctrl nvw_ctrl_sva #(.PWRT_CYCLES(PWRT_CYCLES)) i_sva (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .code_protect(code_protect),
	.ext_req(ext_req), .ext_ack(ext_ack), .ext_denied(ext_denied), .pwrt_running(pwrt_running));

// ==== dv/nvw_ctrl_bench.sv ====
// Self-checking bench for the nonvolatile write controller
`include "nvw_consts.svh"
module nvw_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import nvw_pkg::*;
	logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic code_protect = 0, ext_req = 0, ext_we = 0, pready, pslverr, ext_ack, ext_denied, pwrt_running, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic err;
	logic [7:0] ext_addr = 0;
	nvw_byte_t ext_wdata = 0, ext_rdata;
	int mismatches = 0, checks_done = 0;
	nvw_ctrl #(.PWRT_CYCLES(20), .WRITE_CYCLES(30)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .code_protect(code_protect), .ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr),
		.ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_ack(ext_ack), .ext_denied(ext_denied),
		.pwrt_running(pwrt_running), .irq(irq));
	initial forever #12.5 clk_sys = ~clk_sys;
	// ==========================================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Status in q: bit9 refused, bit8 granted, low byte read data
	task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		ext_req <= 1;
		ext_we <= w;
		ext_addr <= a;
		ext_wdata <= d;
		@(posedge clk_sys);
		ext_req <= 0;
		@(posedge clk_sys);
		q = {22'h0, ext_denied, ext_ack, ext_rdata};
	endtask
	task automatic unlock();
		apb(1, `NVW_OFF_KEY, 32'h55);
		apb(1, `NVW_OFF_KEY, 32'haa);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Whole run is under two hundred cycles
	initial begin
		repeat (4000) @(posedge clk_sys);
		mismatches++;
		final_report();
	end
	// ==========================================================
	// Tests
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1;
		ext(1, 8'h22, 8'h5a);
		chk("ext during power-up", 32'h200, q & 32'h300);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl reset", 32'h0, q);
		apb(0, `NVW_OFF_KEY, 0);
		chk("key read", 32'h0, q);
		chk("mapped no error", 32'h0, {31'h0, err});
		apb(0, 12'h018, 0);
		chk("unmapped error", 32'h1, {31'h0, err});
		while (pwrt_running !== 1'b0) @(posedge clk_sys);
		$display("test power_up done");
		apb(1, `NVW_OFF_DATA, 32'h3c);
		apb(1, `NVW_OFF_ADDR, 32'h21);
		unlock();
		apb(1, `NVW_OFF_CTRL, 32'h06);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl enable with start", 32'h08, q & 32'h0a);
		apb(0, `NVW_OFF_IRQ_STAT, 0);
		chk("status refused", 32'h2, q);
		apb(1, `NVW_OFF_IRQ_STAT, 32'h3);
		apb(1, `NVW_OFF_CTRL, 32'h04);
		$display("test same_write done");
		unlock();
		apb(1, `NVW_OFF_CTRL, 32'h06);
		// Completion interrupt stays masked until the write has been started
		apb(1, `NVW_OFF_IRQ_MASK, 32'h1);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl busy", 32'h06, q);
		apb(1, `NVW_OFF_DATA, 32'h00);
		apb(1, `NVW_OFF_CTRL, 32'h00);
		ext(0, 8'h21, 8'h00);
		chk("ext while busy", 32'h200, q & 32'h300);
		apb(0, `NVW_OFF_CTRL, 0);
		for (int i = 0; i < 40 && q[1]; i++) apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl after write", 32'h04, q);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(0, `NVW_OFF_IRQ_STAT, 0);
		chk("status done", 32'h1, q);
		apb(0, `NVW_OFF_DATA, 0);
		chk("data kept", 32'h3c, q);
		apb(1, `NVW_OFF_IRQ_STAT, 32'h1);
		apb(0, `NVW_OFF_IRQ_STAT, 0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apb(1, `NVW_OFF_CTRL, 32'h00);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl write enable off", 32'h0, q);
		$display("test keyed_write done");
		apb(1, `NVW_OFF_CTRL, 32'h04);
		apb(1, `NVW_OFF_KEY, 32'h55);
		apb(0, `NVW_OFF_CTRL, 0);
		apb(1, `NVW_OFF_KEY, 32'haa);
		apb(1, `NVW_OFF_CTRL, 32'h06);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl broken keys", 32'h0c, q);
		apb(1, `NVW_OFF_CTRL, 32'h84);
		unlock();
		apb(1, `NVW_OFF_CTRL, 32'h87);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl program select", 32'h8c, q);
		apb(1, `NVW_OFF_CTRL, 32'h04);
		ext(1, 8'h22, 8'h5a);
		ext(0, 8'h22, 8'h00);
		chk("ext read", 32'h15a, q);
		code_protect <= 1;
		ext(0, 8'h21, 8'h00);
		chk("ext protected", 32'h200, q & 32'h300);
		apb(1, `NVW_OFF_DATA, 32'h00);
		apb(1, `NVW_OFF_CTRL, 32'h05);
		apb(0, `NVW_OFF_CTRL, 0);
		chk("read bit cleared", 32'h04, q);
		apb(0, `NVW_OFF_DATA, 0);
		chk("cpu read protected", 32'h3c, q);
		$display("test protect done");
		rst_n <= 0;
		@(posedge clk_sys);
		rst_n <= 1;
		apb(0, `NVW_OFF_CTRL, 0);
		chk("ctrl after second reset", 32'h0, q);
		chk("power-up block again", 32'h1, {31'h0, pwrt_running});
		$display("test second_reset done");
		final_report();
	end
endmodule
